// ---- design/dcf_fifo_ctrl.sv ----
module dcf_fifo_ctrl #(
    parameter int DEPTH = dcf_pkg::DEF_DEPTH
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // device pins
    input wire dcf_pkg::dcf_pin_t pins_i,
    input wire dcf_pkg::dcf_strap_t straps_i,
    input wire logic [dcf_pkg::DATA_W-1:0] wdata_i,
    // data and flags
    output logic [dcf_pkg::DATA_W-1:0] rdata_o,
    output logic empty_or_ready_n_o,
    output logic full_or_space_n_o,
    output logic almost_empty_flag_o,
    output logic almost_full_flag_o,
    output logic fall_through_mode_o
);
    import dcf_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);
    localparam int SYNC_W = $bits(dcf_strap_t) + $bits(dcf_pin_t);
    typedef logic [PTR_W:0] cnt_t;     // pointer with wrap bit
    typedef logic [PTR_W-1:0] offs_t;  // offset register

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (DEPTH < MIN_DEPTH || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least MIN_DEPTH");
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] s1, s2, s3, lvl;        // three stages plus filtered level
    logic [SYNC_W-1:0] agree, rise;             // stage agreement, filtered rising edge
    logic [DATA_W-1:0] d1, d2, d3;              // data rides alongside the controls
    dcf_pin_t p, p_rise;                        // filtered pin levels and edges
    dcf_strap_t st;                             // filtered straps

    assign agree = ~(s2 ^ s3);
    assign rise = agree & s3 & ~lvl;
    assign {st, p} = lvl;
    assign p_rise = dcf_pin_t'(rise[$bits(dcf_pin_t)-1:0]);

    // a change counts only once stages two and three agree; stage one feeds stage two alone
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            lvl <= '0;
        end else begin
            s1 <= {straps_i, pins_i};
            s2 <= s1;
            s3 <= s2;
            lvl <= (agree & s3) | (~agree & lvl);
        end
    end

    // data pipeline, no reset needed as it is only sampled on an edge
    always_ff @(posedge ref_clk_i) begin
        d1 <= wdata_i;
        d2 <= d1;
        d3 <= d2;
    end

    // ------------------------------------------------------------
    // resets and configuration
    // ------------------------------------------------------------
    logic init_all;      // master reset in force
    logic clr;           // master or partial reset
    dcf_cfg_t cfg;       // latched configuration

    assign init_all = sys_rst_i | ~p.full_init_n;
    assign clr = init_all | ~p.partial_clear_n;
    assign fall_through_mode_o = cfg.fall_through_mode;

    // straps follow the pins only while master reset holds; afterwards the pins are
    // assumed quiet, so a late change is simply ignored
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cfg <= '0;
        end else if (~p.full_init_n) begin
            cfg.fall_through_mode <= p.fall_through_si & st.sync_read_sel;
            cfg.async_read <= ~st.sync_read_sel;
            cfg.async_write <= ~st.sync_write_sel;
            cfg.flag_sync <= st.flag_timing_sel;
            cfg.rt_normal <= st.retransmit_latency_sel;
            cfg.serial_prog <= ~p.offset_access_sel_n;
            cfg.bus_match <= st.bus_match_sel;
            cfg.read_w <= st.read_width_sel;
            cfg.write_w <= st.write_width_sel;
            cfg.big_endian <= ~st.byte_order_sel;
            cfg.parity <= st.parity_sel;
            cfg.def_sel <= {st.flag_sel, p.offset_access_sel_n};
        end
    end

    // ------------------------------------------------------------
    // port events
    // ------------------------------------------------------------
    logic rd_go, wr_go, rewind, off_mode, push;
    cnt_t wptr, rptr, used, stored, free;
    logic valid;   // output register holds a fallen-through word

    assign rd_go = p_rise.read_clk & (cfg.async_read | ~p.read_gate_n);
    assign wr_go = p_rise.write_clk & (cfg.async_write | ~p.write_gate_n);
    assign rewind = p_rise.read_clk & ~p.rewind_request_n;
    assign off_mode = ~p.offset_access_sel_n;
    assign push = wr_go & ~off_mode & p.serial_offset_load_n & (used != cnt_t'(DEPTH));

    // both pointers live on ref_clk_i after the pin synchronisers, so the
    // count is exact with no further crossing
    assign used = cnt_t'(wptr - rptr);
    assign stored = cnt_t'(used + {{PTR_W{1'b0}}, valid});
    assign free = cnt_t'(cnt_t'(DEPTH) - stored);

    // unused output lanes read as zero in the narrow modes
    function automatic logic [DATA_W-1:0] lane_mask(input dcf_cfg_t c, input logic [DATA_W-1:0] w);
        logic [DATA_W-1:0] m;
        m = '1;
        if (c.bus_match) begin
            m = c.read_w ? DATA_W'({BYTE_W{1'b1}}) : DATA_W'({HALF_W{1'b1}});
        end
        return w & m;
    endfunction : lane_mask

    // ------------------------------------------------------------
    // storage and write pointer
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [DEPTH];   // flop storage

    always_ff @(posedge ref_clk_i) begin
        if (push && !clr) begin
            mem[wptr[PTR_W-1:0]] <= d3;
        end
    end

    // write pointer: rewind never touches it
    always_ff @(posedge ref_clk_i) begin
        if (clr) begin
            wptr <= '0;
        end else if (push) begin
            wptr <= cnt_t'(wptr + 1'b1);
        end
    end

    // ------------------------------------------------------------
    // offset registers
    // ------------------------------------------------------------
    offs_t empty_off, full_off;   // almost-empty and almost-full offsets
    logic wsel, rsel;             // parallel write / read step

    // partial reset leaves the offsets alone, only master reset reloads defaults
    always_ff @(posedge ref_clk_i) begin
        if (init_all) begin
            empty_off <= offs_t'(DEF_OFFSET[cfg.def_sel]);
            full_off <= offs_t'(DEF_OFFSET[cfg.def_sel]);
            wsel <= 1'b0;
        end else if (!p.partial_clear_n) begin
            wsel <= 1'b0;
        end else if (cfg.serial_prog && p_rise.write_clk && !p.serial_offset_load_n) begin
            {full_off, empty_off} <= {full_off[PTR_W-2:0], empty_off, p.fall_through_si};
        end else if (!cfg.serial_prog && wr_go && off_mode) begin
            if (!wsel) begin
                empty_off <= offs_t'(d3);
            end else begin
                full_off <= offs_t'(d3);
            end
            wsel <= ~wsel;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic zero_rew;   // zero-latency rewind refills the output at once
    assign zero_rew = cfg.fall_through_mode & ~cfg.rt_normal & (wptr != '0);

    always_ff @(posedge ref_clk_i) begin
        if (clr) begin
            rptr <= '0;
            rdata_o <= RDATA_RST;
            valid <= 1'b0;
            rsel <= 1'b0;
        end else if (rewind) begin
            // normal latency waits a cycle before the first word falls through
            if (zero_rew) begin
                rdata_o <= lane_mask(cfg, mem[0]);
                rptr <= cnt_t'(1);
                valid <= 1'b1;
            end else begin
                rptr <= '0;
                valid <= 1'b0;
            end
        end else if (rd_go && off_mode) begin
            rdata_o <= lane_mask(cfg, DATA_W'(rsel ? full_off : empty_off));
            rsel <= ~rsel;
        end else if (cfg.fall_through_mode) begin
            if ((rd_go || !valid) && used != '0) begin
                rdata_o <= lane_mask(cfg, mem[rptr[PTR_W-1:0]]);
                rptr <= cnt_t'(rptr + 1'b1);
                valid <= 1'b1;
            end else if (rd_go) begin
                valid <= 1'b0;
            end
        end else if (rd_go && used != '0) begin
            rdata_o <= lane_mask(cfg, mem[rptr[PTR_W-1:0]]);
            rptr <= cnt_t'(rptr + 1'b1);
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    logic ae_now, af_now, ae_q, af_q;

    assign ae_now = stored >= {1'b0, empty_off};
    assign af_now = free > {1'b0, full_off};
    // asynchronous mode follows the count straight away, synchronous adds a stage
    assign almost_empty_flag_o = cfg.flag_sync ? ae_q : ae_now;
    assign almost_full_flag_o = cfg.flag_sync ? af_q : af_now;

    always_ff @(posedge ref_clk_i) begin
        if (clr) begin
            ae_q <= 1'b0;
            af_q <= 1'b1;
        end else begin
            ae_q <= ae_now;
            af_q <= af_now;
        end
    end

    // empty/valid and full/space flags; standard shows empty low, fall-through shows valid low
    always_ff @(posedge ref_clk_i) begin
        if (clr) begin
            empty_or_ready_n_o <= cfg.fall_through_mode;
            full_or_space_n_o <= ~cfg.fall_through_mode;
        end else begin
            if (rewind) begin
                empty_or_ready_n_o <= cfg.fall_through_mode;
            end else if (cfg.fall_through_mode) begin
                empty_or_ready_n_o <= ~valid;
            end else begin
                empty_or_ready_n_o <= (used != '0);
            end
            full_or_space_n_o <= cfg.fall_through_mode ? (used == cnt_t'(DEPTH)) : (used != cnt_t'(DEPTH));
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_rewind;
        !clr && rewind;
    endsequence

    sequence s_partial;
        !init_all && !p.partial_clear_n;
    endsequence

    master_init_a: assert property (init_all |=> wptr == '0 && rptr == '0 && rdata_o == RDATA_RST)
        else $error("master reset left pointers or output set");
    cfg_hold_a: assert property (p.full_init_n |=> $stable(cfg))
        else $error("configuration changed outside master reset");
    partial_keep_a: assert property (s_partial |=> empty_off == $past(empty_off) && full_off == $past(full_off)
        && rptr == '0 && wptr == '0)
        else $error("partial reset lost offsets or kept pointers");
    almost_empty_sync_a: assert property (cfg.flag_sync && !clr && ae_now |=> almost_empty_flag_o)
        else $error("almost-empty flag missed the count");
    almost_full_low_a: assert property (!cfg.flag_sync && free <= {1'b0, full_off} |-> !almost_full_flag_o)
        else $error("almost-full flag high inside the offset");
    rewind_flag_a: assert property (s_rewind |=> empty_or_ready_n_o == cfg.fall_through_mode && rptr <= cnt_t'(1))
        else $error("rewind did not show empty");
    rewind_wptr_a: assert property (s_rewind ##0 !push |=> wptr == $past(wptr))
        else $error("rewind moved the write pointer");
    read_pop_a: assert property (!clr && !rewind && !cfg.fall_through_mode && rd_go && !off_mode
        && used != '0 |=> rptr == cnt_t'($past(rptr) + 1'b1))
        else $error("clocked read did not pop");
    write_push_a: assert property (!clr && push |=> wptr == cnt_t'($past(wptr) + 1'b1))
        else $error("write did not advance the pointer");
    serial_hold_a: assert property (!init_all && p.partial_clear_n && p.serial_offset_load_n && !(wr_go && off_mode)
        |=> $stable(empty_off) && $stable(full_off))
        else $error("offsets changed without a load");
    strobe_mode_a: assert property (cfg.async_read |-> !cfg.fall_through_mode)
        else $error("fall-through combined with strobed read");

endmodule : dcf_fifo_ctrl

// ---- design/dcf_pkg.sv ----
package dcf_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int DATA_W = 36;            // full port width
    localparam int HALF_W = 18;            // narrow port width
    localparam int BYTE_W = 9;             // narrowest port width
    localparam int DEF_DEPTH = 65536;      // words of storage
    localparam int MIN_DEPTH = 2048;       // smallest depth the default offsets fit
    localparam int OFFSET_SEL_N = 8;       // number of default offset choices

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RDATA_RST = 36'h0_0000_0000; // output register after any reset

    // default flag offsets, picked by {flag_sel, offset_access_sel_n} at init
    localparam logic [15:0] DEF_OFFSET [OFFSET_SEL_N] = '{
        16'h0007, 16'h000f, 16'h001f, 16'h003f,
        16'h007f, 16'h00ff, 16'h01ff, 16'h03ff
    };

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    // pins that change during operation
    typedef struct packed {
        logic read_clk;              // read clock or read strobe
        logic write_clk;             // write clock or write strobe
        logic read_gate_n;           // read enable, active low
        logic write_gate_n;          // write enable, active low
        logic rewind_request_n;      // retransmit request, active low
        logic serial_offset_load_n;  // serial offset shift enable, active low
        logic offset_access_sel_n;   // offset register access, active low
        logic fall_through_si;       // mode strap at init, serial data after
        logic full_init_n;           // master reset, active low
        logic partial_clear_n;       // partial reset, active low
    } dcf_pin_t;

    // straps sampled only during master reset
    typedef struct packed {
        logic flag_timing_sel;        // 0 asynchronous, 1 synchronous flags
        logic retransmit_latency_sel; // 0 zero latency, 1 normal latency
        logic [1:0] flag_sel;         // default offset choice
        logic read_width_sel;         // read port width pick
        logic write_width_sel;        // write port width pick
        logic bus_match_sel;          // bus matching on
        logic byte_order_sel;         // 0 big, 1 little endian
        logic parity_sel;             // interspersed parity
        logic sync_read_sel;          // 1 clocked read port, 0 strobed
        logic sync_write_sel;         // 1 clocked write port, 0 strobed
    } dcf_strap_t;

    // configuration held from master reset onward
    typedef struct packed {
        logic fall_through_mode;  // first word falls through to the output
        logic async_read;         // read strobe port
        logic async_write;        // write strobe port
        logic flag_sync;          // almost flags registered
        logic rt_normal;          // normal latency rewind
        logic serial_prog;        // offsets loaded serially
        logic bus_match;          // narrow port widths in use
        logic read_w;             // read width pick
        logic write_w;            // write width pick
        logic big_endian;         // byte order
        logic parity;             // interspersed parity
        logic [2:0] def_sel;      // default offset index
    } dcf_cfg_t;

endpackage : dcf_pkg

// ---- tb/dcf_host_model.sv ----
// write-side and read-side host logic; pin edges spaced by 4 system clocks
module dcf_host_model (
    // system clock used only for pacing
    input wire logic ref_clk_i,
    input wire logic strobed_i,
    // pins towards the fifo
    output logic read_clk_o,
    output logic write_clk_o,
    output logic read_gate_n_o,
    output logic write_gate_n_o,
    output logic [dcf_pkg::DATA_W-1:0] wdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import dcf_pkg::*;

    // ------------------------------------------------------------
    // idle state
    // ------------------------------------------------------------
    initial begin
        read_clk_o = 1'b0;
        write_clk_o = 1'b0;
        read_gate_n_o = 1'b1;
        write_gate_n_o = 1'b1;
        wdata_o = '0;
    end

    // wait n edges, then step just past the edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : wait_clk

    // one write cycle; gates stay low in strobed mode
    task automatic push(input logic [DATA_W-1:0] data, input logic gate_n);
        wait_clk(1);
        wdata_o = data;
        write_gate_n_o = strobed_i ? 1'b0 : gate_n;
        wait_clk(4);
        write_clk_o = 1'b1;
        wait_clk(4);
        write_clk_o = 1'b0;
        wait_clk(4);
        write_gate_n_o = ~strobed_i;
        // released data bus shows the inverse so stale data never looks valid
        wdata_o = ~data;
    endtask : push

    // one read cycle; the caller sets rewind or offset access around it
    task automatic pop(input logic gate_n);
        wait_clk(1);
        read_gate_n_o = strobed_i ? 1'b0 : gate_n;
        wait_clk(4);
        read_clk_o = 1'b1;
        wait_clk(4);
        read_clk_o = 1'b0;
        wait_clk(4);
        read_gate_n_o = ~strobed_i;
    endtask : pop
endmodule : dcf_host_model

// ---- tb/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dcf_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] wdata; // word written
        logic ae;                 // almost-empty after the write
    } dcf_row_t;

    localparam int DEPTH = 2048; // small depth keeps the fill short
    logic ref_clk_i = 1'b0;
    logic sys_rst_i;
    logic rclk, wclk, rgate_n, wgate_n;
    logic rewind_n, sload_n, ofs_n, ft_si, init_n, pclr_n;
    dcf_pin_t pins;
    dcf_strap_t straps;
    logic [DATA_W-1:0] wdata, rdata;
    logic empty_n, full_n, ae, af, ft_mode;
    dcf_row_t rows [16];
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    logic strobed = 1'b0;     // host runs strobed ports with gates held low
    dcf_strap_t alt_straps;   // strap set for a later master reset
    // serial offset image for a depth of 2048: full offset 2046, then empty offset 3, msb first
    localparam logic [21:0] SER_BITS = {11'h7fe, 11'h003};

    assign pins = {rclk, wclk, rgate_n, wgate_n, rewind_n, sload_n, ofs_n, ft_si, init_n, pclr_n};

    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    dcf_fifo_ctrl #(.DEPTH(DEPTH)) u_dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pins_i(pins), .straps_i(straps),
        .wdata_i(wdata), .rdata_o(rdata), .empty_or_ready_n_o(empty_n), .full_or_space_n_o(full_n),
        .almost_empty_flag_o(ae), .almost_full_flag_o(af), .fall_through_mode_o(ft_mode)
    );
    dcf_host_model u_host (
        .ref_clk_i(ref_clk_i), .strobed_i(strobed), .read_clk_o(rclk), .write_clk_o(wclk),
        .read_gate_n_o(rgate_n), .write_gate_n_o(wgate_n), .wdata_o(wdata)
    );

    // clock, and a ceiling well above the roughly 30k cycles the run needs
    always #4 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            err_total++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // compare and helper tasks
    // ------------------------------------------------------------
    task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    // hold a reset pin low long enough for the straps to settle inside
    task automatic pulse_low(ref logic pin);
        u_host.wait_clk(1);
        pin = 1'b0;
        u_host.wait_clk(8);
        pin = 1'b1;
        u_host.wait_clk(10);
    endtask : pulse_low

    // master reset with a new strap set; straps only move while the reset pin is low
    task automatic reinit(input dcf_strap_t s, input logic si, input logic ofs);
        u_host.wait_clk(1);
        init_n = 1'b0;
        straps = s;
        ft_si = si;
        ofs_n = ofs;
        u_host.wait_clk(8);
        init_n = 1'b1;
        u_host.wait_clk(10);
        ofs_n = 1'b1;
    endtask : reinit

    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        // straps for the first init, kept until reinit: standard mode, parallel offsets, index 1
        straps = '0;
        straps.flag_timing_sel = 1'b1;
        straps.retransmit_latency_sel = 1'b1;
        straps.sync_read_sel = 1'b1;
        straps.sync_write_sel = 1'b1;
        {sys_rst_i, init_n, pclr_n, rewind_n, sload_n, ofs_n, ft_si} = 7'b1011110;
        for (int i = 0; i < 16; i++) begin
            rows[i].wdata = {4'(i), 32'h5a5a_0000 ^ 32'(i * 32'h0101_1011)};
            rows[i].ae = (i >= 14);
        end
        rows[0].wdata = 36'hf_ffff_ffff;
        rows[1].wdata = 36'h0_0000_0000;
        repeat (8) @(posedge ref_clk_i);
        #1;
        sys_rst_i = 1'b0;
        pulse_low(init_n);
        chk_word(rdata, RDATA_RST);
        chk_bit(empty_n, 1'b0);
        chk_bit(ae, 1'b0);
        chk_bit(af, 1'b1);
        chk_bit(ft_mode, 1'b0);
        // ordinary cases: write every row, then read every row in order
        foreach (rows[i]) begin
            u_host.push(rows[i].wdata, 1'b0);
            chk_bit(ae, rows[i].ae);
            chk_bit(empty_n, 1'b1);
        end
        foreach (rows[i]) begin
            u_host.pop(1'b0);
            chk_word(rdata, rows[i].wdata);
        end
        chk_bit(empty_n, 1'b0);
        // rewind alone, then reread from the first location
        rewind_n = 1'b0;
        u_host.pop(1'b1);
        rewind_n = 1'b1;
        u_host.pop(1'b0);
        chk_word(rdata, rows[0].wdata);
        u_host.pop(1'b1);
        chk_word(rdata, rows[0].wdata);
        u_host.pop(1'b0);
        chk_word(rdata, rows[1].wdata);
        // offset access: empty then full offset replace the data
        ofs_n = 1'b0;
        repeat (2) begin
            u_host.pop(1'b0);
            chk_word(rdata, DATA_W'(DEF_OFFSET[1]));
        end
        ofs_n = 1'b1;
        // partial reset clears data but keeps the offsets
        pulse_low(pclr_n);
        chk_word(rdata, RDATA_RST);
        chk_bit(empty_n, 1'b0);
        u_host.push(36'h1_2345_6789, 1'b1);
        chk_bit(empty_n, 1'b0);
        // fill to full; almost-full drops once free reaches the offset
        for (int i = 0; i < DEPTH; i++) begin
            u_host.push(DATA_W'(i), 1'b0);
            if (i == 13 || i == 14) chk_bit(ae, i == 14);
            if (i == DEPTH - 17 || i == DEPTH - 16) chk_bit(af, i == DEPTH - 17);
        end
        chk_bit(full_n, 1'b0);
        u_host.push(36'hf_0000_0000, 1'b0);
        u_host.pop(1'b0);
        chk_word(rdata, 36'h0_0000_0000);
        chk_bit(full_n, 1'b1);
        // second master reset in mid-run
        pulse_low(init_n);
        chk_word(rdata, RDATA_RST);
        chk_bit(empty_n, 1'b0);
        chk_bit(af, 1'b1);
        // fall-through, 9-bit reads, async flags, zero-latency rewind, serial offsets
        alt_straps = '0;
        alt_straps.flag_sel = 2'b11;
        alt_straps.read_width_sel = 1'b1;
        alt_straps.bus_match_sel = 1'b1;
        alt_straps.sync_read_sel = 1'b1;
        alt_straps.sync_write_sel = 1'b1;
        reinit(alt_straps, 1'b1, 1'b0);
        chk_bit(ft_mode, 1'b1);
        chk_bit(empty_n, 1'b1);
        chk_bit(full_n, 1'b0);
        chk_bit(af, 1'b1);
        sload_n = 1'b0;
        for (int b = 21; b >= 0; b--) begin
            ft_si = SER_BITS[b];
            u_host.push(36'h0_0000_0000, 1'b1);
        end
        sload_n = 1'b1;
        ofs_n = 1'b0;
        u_host.pop(1'b0);
        chk_word(rdata, 36'h0_0000_0003);
        u_host.pop(1'b0);
        chk_word(rdata, 36'h0_0000_01fe);
        ofs_n = 1'b1;
        u_host.push(36'h1_2345_6789, 1'b0);
        chk_word(rdata, 36'h0_0000_0189);
        chk_bit(empty_n, 1'b0);
        chk_bit(af, 1'b1);
        u_host.push(36'h0_0000_0a5a, 1'b0);
        chk_bit(af, 1'b0);
        chk_bit(ae, 1'b0);
        u_host.push(36'h3_c3c3_c3c3, 1'b0);
        chk_bit(ae, 1'b1);
        u_host.pop(1'b0);
        chk_word(rdata, 36'h0_0000_005a);
        chk_bit(ae, 1'b0);
        rewind_n = 1'b0;
        u_host.pop(1'b1);
        rewind_n = 1'b1;
        chk_word(rdata, 36'h0_0000_0189);
        u_host.pop(1'b0);
        chk_word(rdata, 36'h0_0000_005a);
        pulse_low(pclr_n);
        chk_bit(ft_mode, 1'b1);
        chk_bit(empty_n, 1'b1);
        ofs_n = 1'b0;
        u_host.pop(1'b0);
        chk_word(rdata, 36'h0_0000_0003);
        ofs_n = 1'b1;
        // strobed ports: the fall-through strap is refused with a strobed read port
        alt_straps = '0;
        alt_straps.flag_timing_sel = 1'b1;
        alt_straps.retransmit_latency_sel = 1'b1;
        reinit(alt_straps, 1'b1, 1'b1);
        strobed = 1'b1;
        chk_bit(ft_mode, 1'b0);
        u_host.push(36'h9_8765_4321, 1'b1);
        u_host.push(36'h0_f0f0_f0f0, 1'b1);
        chk_bit(empty_n, 1'b1);
        u_host.pop(1'b1);
        chk_word(rdata, 36'h9_8765_4321);
        u_host.pop(1'b1);
        chk_word(rdata, 36'h0_f0f0_f0f0);
        chk_bit(empty_n, 1'b0);
        print_verdict();
    end
endmodule : tb_top
